// ---- hdl/pci_cfg_map.svh ----
// constants for the processor-to-pci configuration address mapper
//
// Contract
// - An unclaimed read completes normally and returns all ones instead of an error.
// - The window at 8080_08xx selects the isa bridge on AD11, the three slot windows AD12 to AD14.
// - The configuration decode is the same in contiguous and non-contiguous i/o mode.
// - Configuration address bits 2 to 23 go to pci unchanged, apart from undoing the little-endian swizzle; the rest are zero.
// - The two lowest pci address bits are zero on every configuration cycle in either endian mode.
// - Processor address bits 8 to 10 land on pci bits 8 to 10 and pick the adaptor function.
// - Both type 0 and type 1 configuration cycles can be generated.
// - A motherboard register is reached by one single processor transfer.
// - The bridge's own control registers take an index write and then a data transfer.
`ifndef PCI_CFG_MAP_SVH
`define PCI_CFG_MAP_SVH

// ****************************************************************
// address windows
// ****************************************************************
`define CFG_WIN_HI 16'h8080
`define IO_WIN_HI 9'h100
`define PORT_IDX 16'h0CF8
`define PORT_DATA 16'h0CFC
`define IDX_EN_BIT 31
`define ALL_ONES 32'hFFFF_FFFF

// ****************************************************************
// little-endian swizzle masks per access size
// ****************************************************************
`define MUNGE_BYTE 3'h7
`define MUNGE_HALF 3'h6
`define MUNGE_WORD 3'h4
`define MUNGE_DBL 3'h0

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 8
`define ABORT_NS 40
`define ABORT_CYC ((`ABORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- hdl/pci_cfg_pkg.sv ----
// types shared by the configuration address mapper
package pci_cfg_pkg;
  typedef enum logic [1:0] {
    KIND_IO = 2'b00,
    KIND_CFG0 = 2'b01,
    KIND_CFG1 = 2'b10
  } kind_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUS = 2'b01,
    ST_CTRL = 2'b10,
    ST_RESP = 2'b11
  } state_type;
endpackage

// ---- hdl/bcr_store.sv ----
// storage for the indexed bridge control registers
`timescale 1ns/1ns
`default_nettype none
module ctrl_reg_store (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  logic [31:0] mem_ff [0:63];
  logic [31:0] rdata_ff;

  // array itself carries no reset, contents are undefined until written
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem_ff[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= mem_ff[i_addr];
    end
  end

  assign o_rdata = rdata_ff;
endmodule // ctrl_reg_store
`default_nettype wire

// ---- hdl/pci_config_address_mapper.sv ----
// processor loads and stores turned into pci configuration and i/o cycles
`timescale 1ns/1ns
`default_nettype none
`include "pci_cfg_map.svh"
module pci_config_address_mapper
  import pci_cfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_le_mode,
  input wire logic i_noncontig,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [1:0] i_req_size,
  input wire logic [31:0] i_req_addr,
  input wire logic [31:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_rdata,
  output logic o_cyc_valid,
  output kind_type o_cyc_kind,
  output logic o_cyc_write,
  output logic [31:0] o_cyc_addr,
  output logic [31:0] o_cyc_wdata,
  output logic [3:0] o_idsel,
  input wire logic i_cyc_claim,
  input wire logic i_cyc_done,
  input wire logic [31:0] i_cyc_rdata
);
  localparam logic [3:0] ABORT_LAST = 4'(`ABORT_CYC - 1);

  state_type state_ff, nxt_state;
  kind_type kind_ff, nxt_kind;
  logic write_ff, nxt_write;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] idx_ff, nxt_idx;
  logic claimed_ff, nxt_claimed;
  logic abort_ff, nxt_abort;
  logic [3:0] timer_ff, nxt_timer;
  logic [31:0] ctrl_rdata;

  // ****************************************************************
  // request decode
  // ****************************************************************
  wire take = i_req_valid && o_req_ready;
  wire [2:0] munge_mask = (i_req_size == 2'h0) ? `MUNGE_BYTE :
                          (i_req_size == 2'h1) ? `MUNGE_HALF :
                          (i_req_size == 2'h2) ? `MUNGE_WORD : `MUNGE_DBL;
  wire [2:0] low3 = i_le_mode ? (i_req_addr[2:0] ^ munge_mask) : i_req_addr[2:0];
  // mode input deliberately absent from the configuration decode
  wire cfg_win = (i_req_addr[31:16] == `CFG_WIN_HI);
  wire [3:0] win_idsel = i_req_addr[14:11];
  wire cfg_hit = cfg_win && (win_idsel != 4'h0);
  // several selects at once is left to software; all are forwarded as given
  wire [31:0] cfg0_addr = {8'h00, i_req_addr[23:3], low3[2], 2'b00};
  wire io_win = (i_req_addr[31:23] == `IO_WIN_HI);
  wire [15:0] port_contig = {i_req_addr[15:3], low3};
  wire [15:0] port_paged = {i_req_addr[22:12], i_req_addr[4:3], low3};
  wire [15:0] io_port = i_noncontig ? port_paged : port_contig;
  wire idx_port = io_win && (io_port == `PORT_IDX);
  wire data_port = io_win && (io_port == `PORT_DATA);
  wire idx_live = idx_ff[`IDX_EN_BIT];
  // nonzero bus number reaches agents behind a pci-to-pci bridge
  wire type1 = idx_live && (idx_ff[23:16] != 8'h00);
  wire [31:0] cfg1_addr = {8'h00, idx_ff[23:2], 2'b00};
  wire ctrl_wr = take && data_port && !type1 && i_req_write;
  wire claim_now = claimed_ff || i_cyc_claim;
  wire abort_now = !claim_now && (timer_ff == ABORT_LAST);

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_write = write_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_idx = idx_ff;
    nxt_claimed = claimed_ff;
    nxt_abort = abort_ff;
    nxt_timer = timer_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_write = i_req_write;
          nxt_wdata = i_req_wdata;
          nxt_claimed = 1'b0;
          nxt_abort = 1'b0;
          nxt_timer = 4'h0;
          if (idx_port) begin
            // index write only selects, data moves on the next transfer
            nxt_rdata = idx_ff;
            if (i_req_write) begin
              nxt_idx = i_req_wdata;
            end
            nxt_state = ST_RESP;
          end else if (data_port && type1) begin
            nxt_kind = KIND_CFG1;
            nxt_addr = cfg1_addr;
            nxt_state = ST_BUS;
          end else if (data_port) begin
            nxt_state = ST_CTRL;
          end else if (cfg_hit) begin
            nxt_kind = KIND_CFG0;
            nxt_addr = cfg0_addr;
            nxt_state = ST_BUS;
          end else if (io_win) begin
            // one processor transfer becomes one i/o cycle
            nxt_kind = KIND_IO;
            nxt_addr = {16'h0000, io_port};
            nxt_state = ST_BUS;
          end else begin
            nxt_rdata = `ALL_ONES;
            nxt_abort = 1'b1;
            nxt_state = ST_RESP;
          end
        end
      end
      ST_BUS: begin
        nxt_timer = timer_ff + 4'h1;
        if (i_cyc_claim) begin
          nxt_claimed = 1'b1;
        end
        if (i_cyc_done && claim_now) begin
          nxt_rdata = i_cyc_rdata;
          nxt_state = ST_RESP;
        end else if (abort_now) begin
          // nobody answered: finish quietly so a device scan can go on
          nxt_rdata = `ALL_ONES;
          nxt_abort = 1'b1;
          nxt_state = ST_RESP;
        end
      end
      ST_CTRL: begin
        nxt_rdata = ctrl_rdata;
        nxt_state = ST_RESP;
      end
      ST_RESP: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      kind_ff <= KIND_IO;
      write_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
      idx_ff <= 32'h0000_0000;
      claimed_ff <= 1'b0;
      abort_ff <= 1'b0;
      timer_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      write_ff <= nxt_write;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      idx_ff <= nxt_idx;
      claimed_ff <= nxt_claimed;
      abort_ff <= nxt_abort;
      timer_ff <= nxt_timer;
    end
  end

  ctrl_reg_store u_ctrl (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_wr_en(ctrl_wr),
    .i_addr(idx_ff[7:2]),
    .i_wdata(i_req_wdata),
    .o_rdata(ctrl_rdata)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  wire in_bus = (state_ff == ST_BUS);
  assign o_req_ready = (state_ff == ST_IDLE);
  assign o_rsp_valid = (state_ff == ST_RESP);
  assign o_rsp_rdata = rdata_ff;
  assign o_cyc_valid = in_bus;
  assign o_cyc_kind = kind_ff;
  assign o_cyc_write = write_ff;
  assign o_cyc_addr = addr_ff;
  assign o_cyc_wdata = wdata_ff;
  assign o_idsel = (in_bus && kind_ff == KIND_CFG0) ? addr_ff[14:11] : 4'h0;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_take_cfg;
    take && cfg_hit && !idx_port && !data_port;
  endsequence

  sequence s_take_io;
    take && io_win && !idx_port && !data_port && !i_le_mode;
  endsequence

  a_abort_all_ones: assert property (
    (in_bus && !i_cyc_claim && !claimed_ff && timer_ff == ABORT_LAST && !write_ff)
      |=> o_rsp_valid && o_rsp_rdata == 32'hFFFF_FFFF)
    else $error("unclaimed read did not return all ones");

  a_idsel_window: assert property (
    s_take_cfg |=> o_cyc_valid && o_idsel == $past(i_req_addr[14:11]))
    else $error("device select does not follow configuration window");

  a_cfg_mode_free: assert property (
    s_take_cfg |=> o_cyc_kind == KIND_CFG0 && o_cyc_addr[23:11] == $past(i_req_addr[23:11]))
    else $error("configuration decode depends on i/o mode");

  a_addr_unchanged: assert property (
    (s_take_cfg ##0 !i_le_mode) |=> o_cyc_addr[23:2] == $past(i_req_addr[23:2]))
    else $error("configuration address altered in big-endian mode");

  a_cfg_low_zero: assert property (
    (o_cyc_valid && o_cyc_kind != KIND_IO) |-> o_cyc_addr[1:0] == 2'b00)
    else $error("configuration cycle with nonzero low address bits");

  a_func_bits: assert property (
    s_take_cfg |=> o_cyc_addr[10:8] == $past(i_req_addr[10:8]))
    else $error("function bits not carried to pci");

  a_type1_pair: assert property (
    (take && data_port && type1) |=> o_cyc_valid && o_cyc_kind == KIND_CFG1
      && o_cyc_addr[23:16] == $past(idx_ff[23:16]))
    else $error("indexed access did not issue a type 1 cycle");

  a_io_single_map: assert property (
    s_take_io |=> o_cyc_valid && o_cyc_kind == KIND_IO && o_cyc_addr[15:0] ==
      ($past(i_noncontig) ? {$past(i_req_addr[22:12]), $past(i_req_addr[4:0])}
                          : $past(i_req_addr[15:0])))
    else $error("legacy port mapped to wrong i/o address");

  a_bus_bounded: assert property (
    (in_bus && !claimed_ff && !i_cyc_claim) [*5] |=> o_rsp_valid)
    else $error("unclaimed cycle held past the abort time");
endmodule // pci_config_address_mapper
`default_nettype wire

// ---- verif/pci_agent_model.sv ----
// far-side model of the isa bridge and three slot agents
`timescale 1ns/1ns
`default_nettype none
module pci_agent_model
  import pci_cfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cyc_valid,
  input wire kind_type i_cyc_kind,
  input wire logic [31:0] i_cyc_addr,
  input wire logic [3:0] i_idsel,
  input wire logic [3:0] i_present,
  input wire logic [3:0] i_delay,
  output logic o_claim,
  output logic o_done,
  output logic [31:0] o_rdata
);
  // ****************************************************************
  // claim decode
  // ****************************************************************
  logic [3:0] wait_ff;
  logic [31:0] last_ff;
  logic hit;
  // absent agents stay silent, so the bridge must abort
  assign hit = (i_cyc_kind == KIND_CFG0) ? |(i_idsel & i_present) : i_present[0];
  // delay above the abort window means no answer at all
  assign o_claim = i_cyc_valid && hit && (wait_ff == i_delay);
  assign o_done = o_claim;
  // released lines show the inverse of the last value, not a stale copy
  assign o_rdata = o_done ? (i_cyc_addr ^ 32'h5A5A_0000) : ~last_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_cyc_valid)
      wait_ff <= 4'h0;
    else
      wait_ff <= wait_ff + 4'h1;
    if (i_rst)
      last_ff <= 32'h0000_0000;
    else if (o_done)
      last_ff <= o_rdata;
  end
endmodule // pci_agent_model
`default_nettype wire

// ---- verif/pci_config_address_mapper_tb_top.sv ----
// directed bench for the configuration address mapper
`timescale 1ns/1ns
`default_nettype none
module pci_config_address_mapper_tb_top
  import pci_cfg_pkg::*;
;
  logic i_ref_clk, i_rst, i_le_mode, i_noncontig, i_req_valid, i_req_write;
  logic [1:0] i_req_size;
  logic [31:0] i_req_addr, i_req_wdata, o_rsp_rdata, o_cyc_addr, cyc_rdata, rsp_data, s_addr;
  logic [31:0] cyc_wdata, s_wdata;
  logic o_req_ready, o_rsp_valid, o_cyc_valid, o_cyc_write, cyc_claim, cyc_done, seen, s_write;
  kind_type o_cyc_kind;
  logic [1:0] s_kind;
  logic [3:0] o_idsel, s_idsel, present, agent_delay;
  int error_cnt = 0;
  int compares = 0;
  int lat, cyc_cnt = 0;
  pci_config_address_mapper DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_le_mode(i_le_mode),
    .i_noncontig(i_noncontig), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
    .i_req_size(i_req_size), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
    .o_cyc_valid(o_cyc_valid), .o_cyc_kind(o_cyc_kind), .o_cyc_write(o_cyc_write),
    .o_cyc_addr(o_cyc_addr), .o_cyc_wdata(cyc_wdata), .o_idsel(o_idsel), .i_cyc_claim(cyc_claim),
    .i_cyc_done(cyc_done), .i_cyc_rdata(cyc_rdata));
  pci_agent_model agents (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cyc_valid(o_cyc_valid),
    .i_cyc_kind(o_cyc_kind), .i_cyc_addr(o_cyc_addr), .i_idsel(o_idsel), .i_present(present),
    .i_delay(agent_delay), .o_claim(cyc_claim), .o_done(cyc_done), .o_rdata(cyc_rdata));
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, well above the fewer than a hundred cycles the tests need
  always @(posedge i_ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // one request held to the taking edge, then watched to its response
  task automatic xfer(input logic w, input logic [1:0] sz, input logic [31:0] a, d);
    seen = 1'b0;
    i_req_valid = 1'b1;
    i_req_write = w;
    i_req_size = sz;
    i_req_addr = a;
    i_req_wdata = d;
    @(posedge i_ref_clk);
    #1;
    i_req_valid = 1'b0;
    chk("busy ready", 32'h0000_0000, {31'h0, o_req_ready});
    lat = 1;
    while (o_rsp_valid !== 1'b1 && lat < 40) begin
      if (o_cyc_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        s_kind = o_cyc_kind;
        s_addr = o_cyc_addr;
        s_idsel = o_idsel;
        s_write = o_cyc_write;
        s_wdata = cyc_wdata;
      end
      @(posedge i_ref_clk);
      #1;
      lat++;
    end
    // a limit that runs out shows up here as a missing response
    chk("rsp valid", 32'h0000_0001, {31'h0, o_rsp_valid});
    rsp_data = o_rsp_rdata;
    @(posedge i_ref_clk);
    #1;
    chk("rsp pulse", 32'h0000_0000, {31'h0, o_rsp_valid});
    chk("idle ready", 32'h0000_0001, {31'h0, o_req_ready});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_cfg_windows();
    logic [31:0] a, ea;
    present = 4'hF;
    for (int i = 0; i < 4; i++) begin
      // one window at a time, never two selects together
      a = 32'h8080_0506 | (32'h0000_0800 << i);
      // size follows i: half, word and double swizzles in little-endian
      ea = a ^ ((i == 1) ? 32'h0000_0006 : (i == 2) ? 32'h0000_0004 : 32'h0000_0000);
      ea = {8'h00, ea[23:2], 2'h0};
      i_le_mode = (i != 0);
      i_noncontig = i[1];
      agent_delay = 4'(i);
      xfer(1'b0, 2'(i), a, 32'h0000_0000);
      chk("idsel", 32'h0000_0001 << i, {28'h0, s_idsel});
      chk("kind", {30'h0, KIND_CFG0}, {30'h0, s_kind});
      chk("cfg addr", ea, s_addr);
      chk("cfg write", 32'h0000_0000, {31'h0, s_write});
      chk("cfg data", ea ^ 32'h5A5A_0000, rsp_data);
      chk("cfg latency", 32'(2 + i), 32'(lat));
    end
    $display("test cfg_windows done");
  endtask
  task automatic t_scan();
    present = 4'h1;
    i_le_mode = 1'b0;
    xfer(1'b0, 2'h2, 32'h8080_2000, 32'h0000_0000);
    chk("absent data", 32'hFFFF_FFFF, rsp_data);
    chk("abort latency", 32'h0000_0006, 32'(lat));
    xfer(1'b1, 2'h2, 32'h8080_4000, 32'h1111_2222);
    chk("absent write latency", 32'h0000_0006, 32'(lat));
    chk("cfg write", 32'h0000_0001, {31'h0, s_write});
    chk("cfg wdata", 32'h1111_2222, s_wdata);
    xfer(1'b0, 2'h2, 32'h8080_0000, 32'h0000_0000);
    chk("no select data", 32'hFFFF_FFFF, rsp_data);
    chk("no select cycle", 32'h0000_0000, {31'h0, seen});
    xfer(1'b0, 2'h2, 32'h4000_0000, 32'h0000_0000);
    chk("unmapped data", 32'hFFFF_FFFF, rsp_data);
    $display("test scan done");
  endtask
  task automatic t_indexed();
    present = 4'h1;
    agent_delay = 4'h1;
    i_le_mode = 1'b0;
    i_noncontig = 1'b0;
    xfer(1'b1, 2'h2, 32'h8000_0CF8, 32'h8001_0804);
    chk("index latency", 32'h0000_0001, 32'(lat));
    xfer(1'b0, 2'h2, 32'h8000_0CF8, 32'h0000_0000);
    chk("index readback", 32'h8001_0804, rsp_data);
    xfer(1'b0, 2'h2, 32'h8000_0CFC, 32'h0000_0000);
    chk("type1 kind", {30'h0, KIND_CFG1}, {30'h0, s_kind});
    chk("type1 addr", 32'h0001_0804, s_addr);
    chk("type1 data", 32'h5A5B_0804, rsp_data);
    xfer(1'b1, 2'h2, 32'h8000_0CF8, 32'h0000_0024);
    xfer(1'b1, 2'h2, 32'h8000_0CFC, 32'h1234_5678);
    chk("ctrl write latency", 32'h0000_0002, 32'(lat));
    xfer(1'b0, 2'h2, 32'h8000_0CFC, 32'h0000_0000);
    chk("ctrl data", 32'h1234_5678, rsp_data);
    chk("ctrl no cycle", 32'h0000_0000, {31'h0, seen});
    $display("test indexed done");
  endtask
  task automatic t_io();
    present = 4'h1;
    agent_delay = 4'h0;
    // third pass: paged mode with the little-endian byte swizzle
    for (int nc = 0; nc < 3; nc++) begin
      i_noncontig = nc[0] | nc[1];
      i_le_mode = nc[1];
      xfer(1'b0, 2'h0, (nc == 0) ? 32'h8000_0092 : nc[1] ? 32'h8000_4015 : 32'h8000_4012,
        32'h0000_0000);
      chk("io kind", {30'h0, KIND_IO}, {30'h0, s_kind});
      chk("io port", 32'h0000_0092, {16'h0, s_addr[15:0]});
      chk("io latency", 32'h0000_0002, 32'(lat));
    end
    $display("test io done");
  endtask
  initial begin
    i_rst = 1'b1;
    i_le_mode = 1'b0;
    i_noncontig = 1'b0;
    i_req_valid = 1'b0;
    i_req_write = 1'b0;
    i_req_size = 2'h0;
    i_req_addr = 32'h0000_0000;
    i_req_wdata = 32'h0000_0000;
    present = 4'hF;
    agent_delay = 4'h0;
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    t_cfg_windows();
    t_scan();
    t_indexed();
    t_io();
    end_of_test();
  end
endmodule // pci_config_address_mapper_tb_top
`default_nettype wire
